// *** common/mxu_core_if.sv ***
// Internal carrier between the execute core, its ALU and its cycle counter
`timescale 1ns/1ps
interface mxu_core_if;
  import mxu_pkg::*;
  logic [DATA_W-1:0] alu_a;
  logic [DATA_W-1:0] alu_b;
  logic              alu_carry;
  logic              alu_dcarry;
  mxu_fn_e           alu_fn;
  logic [DATA_W-1:0] alu_res;
  logic              alu_carry_res;
  logic              alu_dcarry_res;
  logic              flow_start;
  logic [1:0]        flow_extra;
  logic              flow_skip;
  logic              flow_busy;
  logic              flow_discard;

  modport alu (input alu_a, alu_b, alu_carry, alu_dcarry, alu_fn,
               output alu_res, alu_carry_res, alu_dcarry_res);
  modport flow (input flow_start, flow_extra, flow_skip,
                output flow_busy, flow_discard);
  modport core (output alu_a, alu_b, alu_carry, alu_dcarry, alu_fn,
                input alu_res, alu_carry_res, alu_dcarry_res,
                output flow_start, flow_extra, flow_skip,
                input flow_busy, flow_discard);
endinterface

// *** common/mxu_pkg.sv ***
// Constants, operation codes and ALU functions of the execute unit
// ************************
// Function
// - Destination bit 0 writes the accumulator, 1 writes the file register.
// - The file register operand is a 6-bit direct address, 00h to 3Fh.
// - Add with carry sums register, accumulator and carry; sets C, DC, Z.
// - Addition with register or 8-bit immediate; updates C, DC, Z.
// - AND with register or immediate updates only the zero flag.
// - Bank select copies a 2-bit immediate into the bank bits, one cycle.
// - Bit clear and bit set force one register bit, no flags, one cycle.
// - Test-skip-if-clear discards the fetched next instruction if bit is 0.
// - Test-skip-if-set discards the fetched next instruction if bit is 1.
// - Skips take 1 cycle, 2 when skipping, 3 over a two-word instruction.
// - Near call pushes PC+1, loads 10-bit target plus page bits, 2 cycles.
// - Near jump loads 10-bit target plus page bits, no push, 2 cycles.
// - Far call pushes PC+1, loads 12-bit target, updates page, 3 cycles.
// - Far jump loads 12-bit target, updates page bits, no push, 3 cycles.
// - Accumulator or register clear writes 00h and sets the zero flag.
// - Watchdog clear zeroes counter, prescaler if assigned, sets both flags.
// - Complement inverts the register, writes destination, updates only Z.
// - Decimal adjust after addition fixes the accumulator, updates only C.
// - Decimal adjust after subtraction fixes the accumulator, no flags.
// - Increment and decrement write destination, update only Z, one cycle.
// - Skip forms of increment and decrement change no flag, skip on zero.
// - Software interrupt pushes PC+1 and jumps to vector 002h, no flags.
// ************************
package mxu_pkg;

  localparam int DATA_W  = 8;
  localparam int RADDR_W = 6;
  localparam int PC_W    = 12;
  localparam int NEAR_W  = 10;
  localparam int PAGE_W  = 2;
  localparam int BANK_W  = 2;
  localparam int NIB_W   = 4;

  localparam logic [PC_W-1:0]   SWI_VECTOR = 12'h002;
  localparam logic [PC_W-1:0]   PC_RESET   = 12'h000;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE   = 8'h01;
  localparam logic [NIB_W-1:0]  BCD_MAX    = 4'h9;
  localparam logic [NIB_W-1:0]  BCD_FIX    = 4'h6;

  // Extra cycles after the issue cycle
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_ONE  = 2'h1;
  localparam logic [1:0] EXTRA_TWO  = 2'h2;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD_REG_WITH_CARRY, OP_ADD_ACC_REG, OP_ADD_ACC_IMM,
    OP_AND_ACC_REG, OP_AND_ACC_IMM, OP_BANK_SELECT, OP_BIT_CLEAR,
    OP_BIT_SET, OP_TEST_SKIP_IF_CLEAR, OP_TEST_SKIP_IF_SET, OP_NEAR_CALL,
    OP_NEAR_JUMP, OP_FAR_CALL, OP_FAR_JUMP, OP_CLEAR_ACCUMULATOR,
    OP_CLEAR_REGISTER, OP_WATCHDOG_CLEAR, OP_COMPLEMENT,
    OP_DECIMAL_ADJUST_ADD, OP_DECIMAL_ADJUST_SUB, OP_DECREMENT,
    OP_DECREMENT_SKIP_ZERO, OP_INCREMENT, OP_INCREMENT_SKIP_ZERO,
    OP_SOFTWARE_IRQ
  } mxu_op_e;

  typedef enum logic [2:0] {
    FN_ADD, FN_AND, FN_COM, FN_INC, FN_DEC, FN_DA_ADD, FN_DA_SUB, FN_PASS
  } mxu_fn_e;

endpackage

// *** dv/mxu_exec_unit_sva.sv ***
// Assertion checker for the execute unit ports
`timescale 1ns/1ps
module mxu_exec_unit_sva
  import mxu_pkg::*;
(
  // Watched ports
  input wire logic clock_in, reset_in, instr_valid_in, ready_out,
  input wire mxu_op_e op_in,
  input wire logic [PC_W-1:0] imm_in, pc_out, stack_data_out,
  input wire logic file_we_out, zero_flag_out, stack_push_out,
  input wire logic [DATA_W-1:0] file_wdata_out, accumulator_out,
  input wire logic [1:0] bank_select_bits_out, page_buffer_out,
  input wire logic prescaler_to_watchdog_in, watchdog_counter_clear_out,
  input wire logic prescaler_clear_out, timeout_flag_n_out,
  input wire logic powerdown_flag_n_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);
  wire tk = instr_valid_in && ready_out;
  logic [PC_W-1:0] imm_q, pc_q;
  logic [1:0] pg_q;
  logic psc_q;
  always_ff @(posedge clock_in) begin
    imm_q <= imm_in;
    pc_q <= pc_out;
    pg_q <= page_buffer_out;
    psc_q <= prescaler_to_watchdog_in;
  end
  clear_reg_a:
    assert property (tk && op_in == OP_CLEAR_REGISTER |=> file_we_out
      && file_wdata_out == 8'h00 && zero_flag_out) else $error("clr reg");
  clear_acc_a:
    assert property (tk && op_in == OP_CLEAR_ACCUMULATOR |=>
      accumulator_out == 8'h00 && zero_flag_out) else $error("clr acc");
  bank_sel_a:
    assert property (tk && op_in == OP_BANK_SELECT |=>
      bank_select_bits_out == imm_q[1:0] && ready_out) else $error("bank");
  near_jump_a:
    assert property (tk && op_in == OP_NEAR_JUMP |=> pc_out == {pg_q,
      imm_q[9:0]} && !ready_out ##1 ready_out) else $error("near jump");
  far_call_a:
    assert property (tk && op_in == OP_FAR_CALL |=> stack_push_out &&
      stack_data_out == pc_q + 12'h001 && pc_out == imm_q && page_buffer_out
      == imm_q[11:10] ##1 !ready_out ##1 ready_out) else $error("far call");
  far_jump_a:
    assert property (tk && op_in == OP_FAR_JUMP |=> !stack_push_out &&
      pc_out == imm_q && !ready_out ##1 !ready_out ##1 ready_out)
      else $error("far jmp");
  soft_irq_a:
    assert property (tk && op_in == OP_SOFTWARE_IRQ |=> stack_push_out &&
      pc_out == SWI_VECTOR && stack_data_out == pc_q + 12'h001)
      else $error("swi");
  wdt_clear_a:
    assert property (tk && op_in == OP_WATCHDOG_CLEAR |=>
      watchdog_counter_clear_out && prescaler_clear_out == psc_q &&
      timeout_flag_n_out && powerdown_flag_n_out) else $error("wdt clear");
  one_cycle_a:
    assert property (tk && op_in inside {OP_ADD_ACC_IMM, OP_COMPLEMENT,
      OP_INCREMENT} |=> ready_out) else $error("stall on single op");
endmodule
bind mxu_exec_unit mxu_exec_unit_sva mxu_exec_unit_sva_inst (.*);

// *** dv/mxu_exec_unit_test.sv ***
// Self-checking testbench for the execute unit
`timescale 1ns/1ps
module mxu_exec_unit_test;
  import mxu_pkg::*;
  logic clock_in = 1'b0, reset_in = 1'b1, instr_valid_in = 1'b0;
  mxu_op_e op_in = OP_NOP;
  logic [5:0] reg_addr_in = 6'h00, file_raddr_out, file_waddr_out;
  logic dest_in = 1'b0, next_two_word_in = 1'b0;
  logic prescaler_to_watchdog_in = 1'b0;
  logic [2:0] bit_sel_in = 3'h0;
  logic [11:0] imm_in = 12'h000, pc_out, stack_data_out, sd, pc0;
  logic [7:0] file_rdata_in = 8'h00, file_wdata_out, accumulator_out, wd;
  logic ready_out, discard_out, file_we_out, carry_flag_out, zero_flag_out;
  logic digit_carry_flag_out, stack_push_out, watchdog_counter_clear_out;
  logic prescaler_clear_out, timeout_flag_n_out, powerdown_flag_n_out;
  logic [1:0] bank_select_bits_out, page_buffer_out;
  logic we, push;
  logic [3:0] wdg;
  int stalls, miscompares = 0, num_checks = 0;
  wire [2:0] flg = {carry_flag_out, digit_carry_flag_out, zero_flag_out};
  always #50 clock_in = ~clock_in;
  mxu_exec_unit mxu_exec_unit_inst (.*);
  task automatic check(input logic [19:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Issue one op, count stalls
  task automatic run(mxu_op_e op, logic [7:0] rd = 8'h00, logic d = 1'b0,
                     logic [2:0] b = 3'h0, logic [11:0] im = 12'h000,
                     logic nt = 1'b0);
    pc0 = pc_out;
    @(posedge clock_in);
    {instr_valid_in, op_in, file_rdata_in, dest_in} <= {1'b1, op, rd, d};
    {reg_addr_in, bit_sel_in, imm_in, next_two_word_in} <= {{6{d}}, b, im, nt};
    @(posedge clock_in);
    instr_valid_in <= 1'b0;
    @(negedge clock_in);
    {we, wd, push, sd} = {file_we_out, file_wdata_out,
                          stack_push_out, stack_data_out};
    wdg = {watchdog_counter_clear_out, prescaler_clear_out,
           timeout_flag_n_out, powerdown_flag_n_out};
    if (we === 1'b1) check(file_waddr_out, {6{d}});
    for (stalls = 0; ready_out !== 1'b1 && stalls < 4; stalls++) begin
      check(discard_out, 1'b1);
      @(negedge clock_in);
    end
    if (ready_out !== 1'b1) begin
      miscompares++;
      tally_and_finish;
    end
  endtask
  task automatic t_arith;
    run(OP_ADD_ACC_IMM, 8'h00, 1'b0, 3'h0, 12'h18F, 1'b0);
    check({accumulator_out, flg}, {8'h8F, 3'b000});
    run(OP_ADD_REG_WITH_CARRY, 8'h71);
    check({accumulator_out, flg}, {8'h00, 3'b111});
    run(OP_ADD_ACC_REG, 8'h0F);
    check({accumulator_out, flg}, {8'h0F, 3'b000});
    run(OP_ADD_REG_WITH_CARRY, 8'h0E, 1'b1);
    check({we, wd, accumulator_out, flg}, {9'h11D, 8'h0F, 3'b010});
  endtask
  task automatic t_logic;
    run(OP_AND_ACC_IMM, 8'h00, 1'b0, 3'h0, 12'h0F0, 1'b0);
    check({accumulator_out, flg}, {8'h00, 3'b011});
    run(OP_COMPLEMENT, 8'h5A);
    check({accumulator_out, flg}, {8'hA5, 3'b010});
    run(OP_CLEAR_REGISTER, 8'h77, 1'b1);
    check({we, wd, flg}, {9'h100, 3'b011});
    run(OP_DECREMENT);
    check({accumulator_out, flg}, {8'hFF, 3'b010});
    run(OP_CLEAR_ACCUMULATOR);
    check({accumulator_out, flg}, {8'h00, 3'b011});
    run(OP_INCREMENT, 8'hFF, 1'b1);
    check({we, wd, flg, stalls[1:0]}, {9'h100, 3'b011, 2'h0});
  endtask
  task automatic t_decimal;
    run(OP_ADD_ACC_IMM, 8'h00, 1'b0, 3'h0, 12'h07D, 1'b0);
    run(OP_DECIMAL_ADJUST_ADD);
    check({accumulator_out, flg}, {8'h83, 3'b000});
    run(OP_ADD_ACC_IMM, 8'h00, 1'b0, 3'h0, 12'h090, 1'b0);
    run(OP_DECIMAL_ADJUST_ADD);
    check({accumulator_out, flg}, {8'h73, 3'b100});
    run(OP_DECIMAL_ADJUST_SUB);
    check({accumulator_out, flg}, {8'h6D, 3'b100});
  endtask
  task automatic t_bits;
    run(OP_BIT_SET, 8'h00, 1'b1, 3'h7, 12'h000, 1'b0);
    check({we, wd, flg}, {9'h180, 3'b100});
    run(OP_BIT_CLEAR, 8'hFF, 1'b1, 3'h0, 12'h000, 1'b0);
    check({we, wd, flg}, {9'h1FE, 3'b100});
  endtask
  task automatic skip(mxu_op_e op, logic [7:0] rd, logic nt, int n);
    run(op, rd, 1'b0, 3'h3, 12'h000, nt);
    check(stalls, n);
    check(pc_out, pc0 + 12'(n + 1));
  endtask
  task automatic t_skip;
    skip(OP_TEST_SKIP_IF_CLEAR, 8'hF7, 1'b1, 2);
    skip(OP_TEST_SKIP_IF_CLEAR, 8'h08, 1'b1, 0);
    skip(OP_TEST_SKIP_IF_SET, 8'h08, 1'b0, 1);
    skip(OP_TEST_SKIP_IF_SET, 8'hF7, 1'b1, 0);
    skip(OP_INCREMENT_SKIP_ZERO, 8'hFF, 1'b0, 1);
    check({accumulator_out, flg}, {8'h00, 3'b100});
    skip(OP_DECREMENT_SKIP_ZERO, 8'h05, 1'b1, 0);
    check({accumulator_out, flg}, {8'h04, 3'b100});
  endtask
  task automatic br(mxu_op_e op, logic [11:0] im, pcx, logic [1:0] pg,
                    logic pu, int n);
    run(op, 8'h00, 1'b0, 3'h0, im, 1'b0);
    check({pc_out, page_buffer_out, push, stalls[1:0]}, {pcx, pg, pu, 2'(n)});
    if (pu) check(sd, pc0 + 12'h001);
  endtask
  task automatic t_branch;
    br(OP_BANK_SELECT, 12'h002, 12'h001, 2'h0, 1'b0, 0);
    check(bank_select_bits_out, 2'h2);
    br(OP_NEAR_JUMP, 12'hFFF, 12'h3FF, 2'h0, 1'b0, 1);
    br(OP_FAR_CALL, 12'hC34, 12'hC34, 2'h3, 1'b1, 2);
    br(OP_NEAR_CALL, 12'h005, 12'hC05, 2'h3, 1'b1, 1);
    br(OP_FAR_JUMP, 12'h400, 12'h400, 2'h1, 1'b0, 2);
    br(OP_SOFTWARE_IRQ, 12'h000, 12'h002, 2'h1, 1'b1, 1);
  endtask
  task automatic t_wdt(logic ps);
    @(posedge clock_in);
    prescaler_to_watchdog_in <= ps;
    run(OP_WATCHDOG_CLEAR);
    check(wdg, {1'b1, ps, 2'b11});
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    @(negedge clock_in);
    check({pc_out, timeout_flag_n_out, powerdown_flag_n_out}, 14'h0003);
    t_branch;
    t_arith;
    t_logic;
    t_decimal;
    t_bits;
    t_skip;
    t_wdt(1'b1);
    t_wdt(1'b0);
    tally_and_finish;
  end
endmodule

// *** verilog/mxu_alu.sv ***
// Combinational 8-bit ALU with nibble carry and decimal adjust
`timescale 1ns/1ps
module mxu_alu (
  // Operands and results
  mxu_core_if.alu alu_io
);
  import mxu_pkg::*;

  logic [NIB_W:0]    low_sum;
  logic [DATA_W:0]   full_sum;
  logic [NIB_W-1:0]  lo_nib;
  logic [NIB_W-1:0]  hi_nib;
  logic              fix_lo_add;
  logic              fix_hi_add;
  logic              fix_lo_sub;
  logic              fix_hi_sub;
  logic [NIB_W-1:0]  da_lo;
  logic [NIB_W-1:0]  da_hi;

  // Nibble carry taken from the low half of the same sum
  assign low_sum  = {1'b0, alu_io.alu_a[NIB_W-1:0]}
                  + {1'b0, alu_io.alu_b[NIB_W-1:0]}
                  + {{NIB_W{1'b0}}, alu_io.alu_carry};
  assign full_sum = {1'b0, alu_io.alu_a} + {1'b0, alu_io.alu_b}
                  + {{DATA_W{1'b0}}, alu_io.alu_carry};

  assign lo_nib     = alu_io.alu_a[NIB_W-1:0];
  assign hi_nib     = alu_io.alu_a[DATA_W-1:NIB_W];
  assign fix_lo_add = alu_io.alu_dcarry | (lo_nib > BCD_MAX);
  assign fix_hi_add = alu_io.alu_carry | (hi_nib > BCD_MAX)
                    | ((hi_nib == BCD_MAX) & fix_lo_add & (lo_nib > BCD_MAX));
  assign fix_lo_sub = ~alu_io.alu_dcarry | (lo_nib > BCD_MAX);
  assign fix_hi_sub = ~alu_io.alu_carry | (hi_nib > BCD_MAX);
  assign da_lo = (alu_io.alu_fn == FN_DA_SUB)
               ? lo_nib - (fix_lo_sub ? BCD_FIX : 4'h0)
               : lo_nib + (fix_lo_add ? BCD_FIX : 4'h0);
  assign da_hi = (alu_io.alu_fn == FN_DA_SUB)
               ? hi_nib - (fix_hi_sub ? BCD_FIX : 4'h0)
                 - {3'h0, fix_lo_sub & (lo_nib < BCD_FIX)}
               : hi_nib + (fix_hi_add ? BCD_FIX : 4'h0)
                 + {3'h0, fix_lo_add & (lo_nib > BCD_MAX)};

  always_comb begin
    alu_io.alu_res        = alu_io.alu_a;
    alu_io.alu_carry_res  = alu_io.alu_carry;
    alu_io.alu_dcarry_res = alu_io.alu_dcarry;
    unique case (alu_io.alu_fn)
      FN_ADD: begin
        alu_io.alu_res        = full_sum[DATA_W-1:0];
        alu_io.alu_carry_res  = full_sum[DATA_W];
        alu_io.alu_dcarry_res = low_sum[NIB_W];
      end
      FN_AND:    alu_io.alu_res = alu_io.alu_a & alu_io.alu_b;
      FN_COM:    alu_io.alu_res = ~alu_io.alu_b;
      FN_INC:    alu_io.alu_res = alu_io.alu_b + ONE_BYTE;
      FN_DEC:    alu_io.alu_res = alu_io.alu_b - ONE_BYTE;
      FN_DA_ADD: begin
        alu_io.alu_res       = {da_hi, da_lo};
        alu_io.alu_carry_res = alu_io.alu_carry | fix_hi_add;
      end
      FN_DA_SUB: alu_io.alu_res = {da_hi, da_lo};
      FN_PASS:   alu_io.alu_res = alu_io.alu_b;
    endcase
  end
endmodule

// *** verilog/mxu_exec_unit.sv ***
// Execute stage of the 8-bit accumulator core
`timescale 1ns/1ps
module mxu_exec_unit (
  // Clock and reset
  input  wire logic                         clock_in,
  input  wire logic                         reset_in,
  // Instruction issue
  input  wire logic                         instr_valid_in,
  input  wire mxu_pkg::mxu_op_e             op_in,
  input  wire logic [mxu_pkg::RADDR_W-1:0]  reg_addr_in,
  input  wire logic                         dest_in,
  input  wire logic [2:0]                   bit_sel_in,
  input  wire logic [mxu_pkg::PC_W-1:0]     imm_in,
  input  wire logic                         next_two_word_in,
  output      logic                         ready_out,
  output      logic                         discard_out,
  // File register access
  output      logic [mxu_pkg::RADDR_W-1:0]  file_raddr_out,
  input  wire logic [mxu_pkg::DATA_W-1:0]   file_rdata_in,
  output      logic                         file_we_out,
  output      logic [mxu_pkg::RADDR_W-1:0]  file_waddr_out,
  output      logic [mxu_pkg::DATA_W-1:0]   file_wdata_out,
  // Core state
  output      logic [mxu_pkg::DATA_W-1:0]   accumulator_out,
  output      logic                         carry_flag_out,
  output      logic                         digit_carry_flag_out,
  output      logic                         zero_flag_out,
  output      logic [mxu_pkg::BANK_W-1:0]   bank_select_bits_out,
  output      logic [mxu_pkg::PAGE_W-1:0]   page_buffer_out,
  output      logic [mxu_pkg::PC_W-1:0]     pc_out,
  // Stack
  output      logic                         stack_push_out,
  output      logic [mxu_pkg::PC_W-1:0]     stack_data_out,
  // Watchdog
  input  wire logic                         prescaler_to_watchdog_in,
  output      logic                         watchdog_counter_clear_out,
  output      logic                         prescaler_clear_out,
  output      logic                         timeout_flag_n_out,
  output      logic                         powerdown_flag_n_out
);
  import mxu_pkg::*;

  // ************************
  // Internal state
  // ************************
  logic [DATA_W-1:0]  accumulator;
  logic               carry_flag;
  logic               digit_carry_flag;
  logic               zero_flag;
  logic [BANK_W-1:0]  bank_select_bits;
  logic [PAGE_W-1:0]  page_buffer;
  logic [PC_W-1:0]    pc;
  logic               wr_pending;
  logic [RADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0]  wr_data;
  logic               timeout_flag_n;
  logic               powerdown_flag_n;
  logic               push_pulse;
  logic [PC_W-1:0]    push_data;
  logic               wdt_pulse;
  logic               pre_pulse;

  mxu_core_if core_bus ();

  mxu_alu u_alu (
    .alu_io (core_bus.alu)
  );

  mxu_flow u_flow (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .flow_io  (core_bus.flow)
  );

  // ************************
  // Issue and operation decode
  // ************************
  wire take = instr_valid_in & ~core_bus.flow_busy;

  wire is_adc    = (op_in == OP_ADD_REG_WITH_CARRY);
  wire is_add_r  = (op_in == OP_ADD_ACC_REG);
  wire is_add_i  = (op_in == OP_ADD_ACC_IMM);
  wire is_and_r  = (op_in == OP_AND_ACC_REG);
  wire is_and_i  = (op_in == OP_AND_ACC_IMM);
  wire is_bank   = (op_in == OP_BANK_SELECT);
  wire is_bclr   = (op_in == OP_BIT_CLEAR);
  wire is_bset   = (op_in == OP_BIT_SET);
  wire is_tsc    = (op_in == OP_TEST_SKIP_IF_CLEAR);
  wire is_tss    = (op_in == OP_TEST_SKIP_IF_SET);
  wire is_ncall  = (op_in == OP_NEAR_CALL);
  wire is_njmp   = (op_in == OP_NEAR_JUMP);
  wire is_far_call_op  = (op_in == OP_FAR_CALL);
  wire is_fjmp   = (op_in == OP_FAR_JUMP);
  wire is_clear_accumulator_op   = (op_in == OP_CLEAR_ACCUMULATOR);
  wire is_clear_register_op   = (op_in == OP_CLEAR_REGISTER);
  wire is_wdtc   = (op_in == OP_WATCHDOG_CLEAR);
  wire is_com    = (op_in == OP_COMPLEMENT);
  wire is_daa    = (op_in == OP_DECIMAL_ADJUST_ADD);
  wire is_das    = (op_in == OP_DECIMAL_ADJUST_SUB);
  wire is_dec    = (op_in == OP_DECREMENT);
  wire is_decsz  = (op_in == OP_DECREMENT_SKIP_ZERO);
  wire is_inc    = (op_in == OP_INCREMENT);
  wire is_incsz  = (op_in == OP_INCREMENT_SKIP_ZERO);
  wire is_swi    = (op_in == OP_SOFTWARE_IRQ);

  // Operation groups
  wire is_add_any = is_adc | is_add_r | is_add_i;
  wire is_and_any = is_and_r | is_and_i;
  wire is_imm_op  = is_add_i | is_and_i;
  wire is_step    = is_inc | is_dec | is_incsz | is_decsz;
  wire is_da      = is_daa | is_das;
  wire is_bit_wr  = is_bclr | is_bset;
  wire is_near    = is_ncall | is_njmp;
  wire is_far     = is_far_call_op | is_fjmp;
  wire is_push    = is_ncall | is_far_call_op | is_swi;
  wire has_dest   = is_adc | is_add_r | is_and_r | is_com | is_step;

  // ************************
  // File register read with bypass of the pending write
  // ************************
  assign file_raddr_out = reg_addr_in;
  wire   bypass         = wr_pending & (wr_addr == reg_addr_in);
  wire [DATA_W-1:0] reg_val = bypass ? wr_data : file_rdata_in;

  // ************************
  // ALU operand and function selection
  // ************************
  wire [DATA_W-1:0] imm_byte = imm_in[DATA_W-1:0];

  assign core_bus.alu_a = accumulator;
  assign core_bus.alu_b = is_imm_op ? imm_byte : reg_val;
  // Plain addition adds with a forced zero carry
  assign core_bus.alu_carry  = (is_adc | is_da) ? carry_flag : 1'b0;
  assign core_bus.alu_dcarry = digit_carry_flag;
  assign core_bus.alu_fn = is_add_any ? FN_ADD
                         : is_and_any ? FN_AND
                         : is_com     ? FN_COM
                         : (is_inc | is_incsz) ? FN_INC
                         : (is_dec | is_decsz) ? FN_DEC
                         : is_daa     ? FN_DA_ADD
                         : is_das     ? FN_DA_SUB
                         : FN_PASS;

  wire [DATA_W-1:0] alu_res  = core_bus.alu_res;
  wire              res_zero = (alu_res == ZERO_BYTE);

  // ************************
  // Bit operations and skip conditions
  // ************************
  wire [DATA_W-1:0] bit_mask = ONE_BYTE << bit_sel_in;
  wire              bit_val  = |(reg_val & bit_mask);
  wire [DATA_W-1:0] bit_res  = is_bset ? (reg_val | bit_mask)
                                       : (reg_val & ~bit_mask);

  wire skip_tsc  = is_tsc & ~bit_val;
  wire skip_tss  = is_tss & bit_val;
  wire skip_step = (is_incsz | is_decsz) & res_zero;
  wire do_skip   = skip_tsc | skip_tss | skip_step;

  // ************************
  // Destination and write-back selection
  // ************************
  wire to_file = (has_dest & dest_in) | is_bit_wr | is_clear_register_op;
  wire to_acc  = (has_dest & ~dest_in) | is_imm_op | is_clear_accumulator_op
               | is_da;
  wire [DATA_W-1:0] wb_data = is_bit_wr ? bit_res
                            : (is_clear_accumulator_op | is_clear_register_op) ? ZERO_BYTE
                            : alu_res;

  // ************************
  // Flag update enables
  // ************************
  wire upd_c   = is_add_any | is_daa;
  wire upd_dc  = is_add_any;
  wire upd_z   = is_add_any | is_and_any | is_com | is_inc | is_dec;
  wire force_z = is_clear_accumulator_op | is_clear_register_op;

  // ************************
  // Program flow targets
  // ************************
  wire [PC_W-1:0] pc_inc      = pc + {{(PC_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] near_target = {page_buffer, imm_in[NEAR_W-1:0]};
  wire [PC_W-1:0] far_target  = imm_in;
  wire [PC_W-1:0] next_pc =
      is_near ? near_target
    : is_far  ? far_target
    : is_swi  ? SWI_VECTOR
    : pc_inc;

  // A skip over a two-word instruction discards both of its words
  wire [1:0] extra =
      is_far                   ? EXTRA_TWO
    : (is_near | is_swi)       ? EXTRA_ONE
    : (do_skip & next_two_word_in) ? EXTRA_TWO
    : do_skip                  ? EXTRA_ONE
    : EXTRA_NONE;

  assign core_bus.flow_start = take;
  assign core_bus.flow_extra = extra;
  assign core_bus.flow_skip  = do_skip;

  // ************************
  // Accumulator and flags
  // ************************
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      accumulator <= ZERO_BYTE;
    end else if (take & to_acc) begin
      accumulator <= wb_data;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      carry_flag       <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag        <= 1'b0;
    end else if (take) begin
      if (upd_c) begin
        carry_flag <= core_bus.alu_carry_res;
      end
      if (upd_dc) begin
        digit_carry_flag <= core_bus.alu_dcarry_res;
      end
      if (force_z) begin
        zero_flag <= 1'b1;
      end else if (upd_z) begin
        zero_flag <= res_zero;
      end
    end
  end

  // ************************
  // Bank and page selection
  // ************************
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      bank_select_bits <= {BANK_W{1'b0}};
    end else if (take & is_bank) begin
      bank_select_bits <= imm_in[BANK_W-1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      page_buffer <= {PAGE_W{1'b0}};
    end else if (take & is_far) begin
      page_buffer <= imm_in[PC_W-1:NEAR_W];
    end
  end

  // ************************
  // File register write-back, issued the cycle after execute
  // ************************
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wr_pending <= 1'b0;
      wr_addr    <= {RADDR_W{1'b0}};
      wr_data    <= ZERO_BYTE;
    end else begin
      wr_pending <= take & to_file;
      if (take & to_file) begin
        wr_addr <= reg_addr_in;
        wr_data <= wb_data;
      end
    end
  end

  // ************************
  // Program counter and stack push
  // ************************
  // Discarded words still occupy program addresses, so a skip advances
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pc <= PC_RESET;
    end else if (take) begin
      pc <= next_pc;
    end else if (core_bus.flow_discard) begin
      pc <= pc_inc;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      push_pulse <= 1'b0;
      push_data  <= PC_RESET;
    end else begin
      push_pulse <= take & is_push;
      if (take & is_push) begin
        push_data <= pc_inc;
      end
    end
  end

  // ************************
  // Watchdog clear
  // ************************
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wdt_pulse        <= 1'b0;
      pre_pulse        <= 1'b0;
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else begin
      wdt_pulse <= take & is_wdtc;
      pre_pulse <= take & is_wdtc & prescaler_to_watchdog_in;
      if (take & is_wdtc) begin
        timeout_flag_n   <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end
    end
  end

  // ************************
  // Outputs
  // ************************
  assign ready_out                  = ~core_bus.flow_busy;
  assign discard_out                = core_bus.flow_busy;
  assign file_we_out                = wr_pending;
  assign file_waddr_out             = wr_addr;
  assign file_wdata_out             = wr_data;
  assign accumulator_out            = accumulator;
  assign carry_flag_out             = carry_flag;
  assign digit_carry_flag_out       = digit_carry_flag;
  assign zero_flag_out              = zero_flag;
  assign bank_select_bits_out       = bank_select_bits;
  assign page_buffer_out            = page_buffer;
  assign pc_out                     = pc;
  assign stack_push_out             = push_pulse;
  assign stack_data_out             = push_data;
  assign watchdog_counter_clear_out = wdt_pulse;
  assign prescaler_clear_out        = pre_pulse;
  assign timeout_flag_n_out         = timeout_flag_n;
  assign powerdown_flag_n_out       = powerdown_flag_n;

endmodule

// *** verilog/mxu_flow.sv ***
// Extra-cycle counter for branches and skips
`timescale 1ns/1ps
module mxu_flow (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Issue and stall
  mxu_core_if.flow flow_io
);
  import mxu_pkg::*;

  logic [1:0] remain;
  logic       skipping;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      remain   <= EXTRA_NONE;
      skipping <= 1'b0;
    end else if (flow_io.flow_start) begin
      remain   <= flow_io.flow_extra;
      skipping <= flow_io.flow_skip;
    end else if (remain != EXTRA_NONE) begin
      remain   <= remain - EXTRA_ONE;
    end
  end

  assign flow_io.flow_busy    = (remain != EXTRA_NONE);
  assign flow_io.flow_discard = flow_io.flow_busy & skipping;
endmodule
